// File: eehc_bit.sv
// Bit engine: makes the serial clock by a divider and shapes Start, Stop,
// one written bit or one read bit per command in four quarter phases.
// Assumes the data pin is open drain with a pull-up outside.
`timescale 1ns/100ps
module eehc_bit #(
    parameter int QUARTER = eehc_pkg::QUARTER_CYCLES
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             go,
    input  eehc_pkg::eehc_bit_t   cmd,
    input  wire logic             tx_bit,
    input  wire logic             sda_i,
    output logic                  done,
    output logic                  rx_bit,
    output logic                  bus_idle,
    output logic                  scl_o,
    output logic                  sda_oe
);
    import eehc_pkg::*;

    eehc_bit_t   cmd_reg;
    logic        meta_reg;
    logic        sync_reg;
    logic        bit_reg;
    logic        busy_reg;
    logic [1:0]  phase_reg;
    logic [15:0] qcnt_reg;
    logic        scl_reg;
    logic        oe_reg;
    logic        done_reg;
    logic        rx_reg;

    // Clock level for each phase of a command.
    function automatic logic scl_lvl(eehc_bit_t c, logic [1:0] p);
        scl_lvl = (c == BIT_STOP) ? (p != 2'd0) : (p == 2'd1 || p == 2'd2);
    endfunction

    // Data pulled low for each phase of a command.
    function automatic logic pull_lvl(eehc_bit_t c, logic [1:0] p, logic b);
        case (c)
            BIT_START: pull_lvl = p[1];
            BIT_STOP:  pull_lvl = !p[1];
            BIT_WRITE: pull_lvl = !b;
            default:   pull_lvl = 1'b0;
        endcase
    endfunction

    wire       q_end   = qcnt_reg == 16'(QUARTER - 1);
    wire       last    = busy_reg && q_end && phase_reg == 2'd3;
    wire       start_w = go && !busy_reg;
    wire       busy_n  = start_w || (busy_reg && !last);
    eehc_bit_t cmd_n;
    assign     cmd_n   = start_w ? cmd : cmd_reg;
    wire       bit_n   = start_w ? tx_bit : bit_reg;
    wire [1:0] phase_n = start_w ? 2'd0 :
                         (busy_reg && q_end) ? phase_reg + 2'd1 : phase_reg;
    wire       samp    = busy_reg && q_end && phase_reg == 2'd2;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= 1'b1;
            sync_reg <= 1'b1;
        end else begin
            meta_reg <= sda_i;
            sync_reg <= meta_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cmd_reg   <= BIT_STOP;
            bit_reg   <= 1'b1;
            busy_reg  <= 1'b0;
            phase_reg <= 2'd0;
            qcnt_reg  <= 16'h0000;
        end else begin
            cmd_reg   <= cmd_n;
            bit_reg   <= bit_n;
            busy_reg  <= busy_n;
            phase_reg <= phase_n;
            qcnt_reg  <= (start_w || q_end) ? 16'h0000 : qcnt_reg + 16'h0001;
        end
    end

    // Levels change only at phase boundaries, so data moves with clock low except in Start and Stop.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            scl_reg  <= 1'b1;
            oe_reg   <= 1'b0;
            done_reg <= 1'b0;
            rx_reg   <= 1'b1;
        end else begin
            scl_reg  <= busy_n ? scl_lvl(cmd_n, phase_n) : scl_reg;
            oe_reg   <= busy_n ? pull_lvl(cmd_n, phase_n, bit_n) : oe_reg;
            done_reg <= last;
            rx_reg   <= samp ? sync_reg : rx_reg;
        end
    end

    assign done     = done_reg;
    assign rx_bit   = rx_reg;
    assign bus_idle = scl_reg && sync_reg && !busy_reg;
    assign scl_o    = scl_reg;
    assign sda_oe   = oe_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_SDA_STABLE_HIGH: assert property (
        (busy_reg && cmd_reg[1] && scl_reg && $past(scl_reg))
            |-> $stable(oe_reg))
        else $error("Data moved while clock high in a data bit.");
    AST_START_SHAPE: assert property (
        ($rose(oe_reg) && scl_reg) |-> cmd_reg == BIT_START)
        else $error("Data fell under high clock outside a Start.");
    AST_STOP_SHAPE: assert property (
        ($fell(oe_reg) && scl_reg) |-> cmd_reg == BIT_STOP)
        else $error("Data rose under high clock outside a Stop.");
endmodule

// File: eehc_ctrl.sv
// Host controller for a two-wire serial EEPROM with an Avalon-MM slave.
// Assumes sda_o and sda_oe drive an open-drain data wire with pull-up,
// and that the EEPROM samples the push-pull clock on scl_o.
//
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/100ps
// What this block does
// - Data changes only while clock low, except for Start and Stop.
// - Start is data falling under high clock; every command opens so.
// - Stop is data rising under high clock; every operation closes so.
// - Host starts a transfer only when both lines are high.
// - Every byte gets an acknowledge slot in a ninth clock.
// - Host ends a read by not acknowledging the last byte.
// - Byte write is control, address, data, then Stop starts writing.
// - Host keeps each page write inside one aligned sixteen-byte page.
// - Host polls busy by Start plus write control byte until acked; each OP_POLL sends one poll, and software repeats it.
// - Random read sets the address by write, then repeated Start.
module eehc_ctrl #(
    parameter int QUARTER = eehc_pkg::QUARTER_CYCLES
) (
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output logic             scl_o,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    output logic             wp_o
);
    import eehc_pkg::*;

    logic        wait_reg;
    logic [31:0] rdata_reg;
    logic [9:0]  addr_reg;
    logic [4:0]  len_reg;
    logic        wp_reg;
    logic        sda_o_reg;
    eehc_op_t    op_reg;
    logic        busy_reg;
    logic        nack_reg;
    logic        done_reg;
    logic        refused_reg;
    logic [7:0]  buf_mem [16];

    eehc_state_t state_reg, state_next;
    eehc_kind_t  kind_reg, kind_next;
    eehc_bit_t   gcmd_reg, gcmd_next;
    logic        pend_reg, pend_next;
    logic        go_reg, go_next;
    logic        gbit_reg, gbit_next;
    logic [7:0]  shift_reg, shift_next;
    logic [2:0]  bcnt_reg, bcnt_next;
    logic [4:0]  idx_reg, idx_next;
    logic        rphase_reg, rphase_next;
    logic        nack_set;
    logic        done_set;
    logic        buf_we;

    logic        bdone;
    logic        brx;
    logic        bus_idle;

    eehc_bit #(
        .QUARTER (QUARTER)
    ) u_bit (
        .clk      (clk),
        .rst_b    (rst_b),
        .go       (go_reg),
        .cmd      (gcmd_reg),
        .tx_bit   (gbit_reg),
        .sda_i    (sda_i),
        .done     (bdone),
        .rx_bit   (brx),
        .bus_idle (bus_idle),
        .scl_o    (scl_o),
        .sda_oe   (sda_oe)
    );

    // Bus decode; the answer comes one cycle after the request appears.
    wire       req      = avs_read || avs_write;
    wire       wr_take  = avs_write && !wait_reg;
    wire       is_buf   = avs_address[7:6] == BUF_SEL;
    wire [3:0] buf_idx  = avs_address[5:2];
    wire       cfg_wr   = wr_take && !busy_reg;
    wire       cmd_wr   = cfg_wr && avs_address == OFS_CTRL;
    eehc_op_t  op_w;
    assign     op_w     = eehc_op_t'(avs_writedata[2:0]);
    wire       op_ok    = op_w != OP_NONE && op_w <= OP_RAND_READ;
    wire [4:0] page_end = {1'b0, addr_reg[3:0]} + len_reg;
    wire       page_bad = op_w == OP_WRITE && page_end > PAGE_BYTES;
    wire       len_bad  = op_w != OP_POLL &&
                          (len_reg == 5'h00 || len_reg > PAGE_BYTES);
    wire       launch   = cmd_wr && op_ok && !page_bad && !len_bad &&
                          bus_idle;
    wire       refuse   = cmd_wr && !launch;

    wire [4:0]  idx_inc = idx_reg + 5'h01;
    wire        last_rx = idx_inc == len_reg;
    wire        in_stop = state_reg == S_STOP;
    wire [31:0] stat_w  = {27'h0000000, bus_idle, refused_reg, done_reg,
                           nack_reg, busy_reg};
    wire [31:0] rd_mux  =
        (avs_address == OFS_CTRL) ? {29'h00000000, op_reg} :
        (avs_address == OFS_ADDR) ? {22'h000000, addr_reg} :
        (avs_address == OFS_LEN)  ? {27'h0000000, len_reg} :
        (avs_address == OFS_STAT) ? stat_w :
        (avs_address == OFS_CFG)  ? {31'h00000000, wp_reg} :
        is_buf                    ? {24'h000000, buf_mem[buf_idx]} :
                                    32'h00000000;

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_reg  <= 1'b1;
            rdata_reg <= 32'h00000000;
        end else begin
            wait_reg  <= !(req && wait_reg);
            rdata_reg <= (avs_read && wait_reg) ? rd_mux : rdata_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr_reg  <= ADDR_RST;
            len_reg   <= LEN_RST;
            wp_reg    <= WP_RST;
            op_reg    <= OP_NONE;
            sda_o_reg <= 1'b0;
        end else begin
            if (cfg_wr && avs_address == OFS_ADDR)
                addr_reg <= avs_writedata[9:0];
            if (cfg_wr && avs_address == OFS_LEN)
                len_reg <= avs_writedata[4:0];
            if (cfg_wr && avs_address == OFS_CFG)
                wp_reg <= avs_writedata[0];
            if (launch)
                op_reg <= op_w;
        end
    end

    // Status flags: hardware sets take priority over the clear on a new order.
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            busy_reg    <= 1'b0;
            nack_reg    <= 1'b0;
            done_reg    <= 1'b0;
            refused_reg <= 1'b0;
        end else begin
            busy_reg    <= launch || (busy_reg && !done_set);
            nack_reg    <= nack_set || (nack_reg && !cmd_wr);
            done_reg    <= done_set || (done_reg && !cmd_wr);
            refused_reg <= refuse || (refused_reg && !cmd_wr);
        end
    end

    always_ff @(posedge clk) begin
        if (cfg_wr && is_buf)
            buf_mem[buf_idx] <= avs_writedata[7:0];
        else if (buf_we)
            buf_mem[idx_reg[3:0]] <= {shift_reg[6:0], brx};
    end

    // Byte sequencer: each state other than S_IDLE issues one bit command, advances on done.
    always_comb begin
        state_next  = state_reg;
        kind_next   = kind_reg;
        gcmd_next   = gcmd_reg;
        pend_next   = pend_reg;
        go_next     = 1'b0;
        gbit_next   = gbit_reg;
        shift_next  = shift_reg;
        bcnt_next   = bcnt_reg;
        idx_next    = idx_reg;
        rphase_next = rphase_reg;
        nack_set    = 1'b0;
        done_set    = 1'b0;
        buf_we      = 1'b0;
        if (state_reg != S_IDLE && !pend_reg) begin
            go_next   = 1'b1;
            pend_next = 1'b1;
            case (state_reg)
                S_START: gcmd_next = BIT_START;
                S_TX: begin
                    gcmd_next = BIT_WRITE;
                    gbit_next = shift_reg[7];
                end
                S_RXACK: begin
                    gcmd_next = BIT_WRITE;
                    gbit_next = last_rx;
                end
                S_STOP:  gcmd_next = BIT_STOP;
                default: gcmd_next = BIT_READ;
            endcase
        end
        case (state_reg)
            S_IDLE: begin
                if (launch) begin
                    state_next  = S_START;
                    pend_next   = 1'b0;
                    idx_next    = 5'h00;
                    rphase_next = op_w == OP_CUR_READ;
                end
            end
            S_START: begin
                if (pend_reg && bdone) begin
                    pend_next  = 1'b0;
                    shift_next = {TYPE_CODE, 1'b0, addr_reg[9:8],
                                  rphase_reg};
                    kind_next  = rphase_reg ? K_CTRLR : K_CTRLW;
                    bcnt_next  = 3'd0;
                    state_next = S_TX;
                end
            end
            S_TX: begin
                if (pend_reg && bdone) begin
                    pend_next  = 1'b0;
                    shift_next = {shift_reg[6:0], 1'b0};
                    bcnt_next  = bcnt_reg + 3'd1;
                    if (bcnt_reg == 3'd7)
                        state_next = S_TXACK;
                end
            end
            S_TXACK: begin
                if (pend_reg && bdone) begin
                    pend_next = 1'b0;
                    if (brx) begin
                        nack_set   = 1'b1;
                        state_next = S_STOP;
                    end else begin
                        case (kind_reg)
                            K_CTRLW: begin
                                if (op_reg == OP_POLL) begin
                                    state_next = S_STOP;
                                end else begin
                                    shift_next = addr_reg[7:0];
                                    kind_next  = K_ADDR;
                                    state_next = S_TX;
                                end
                            end
                            K_ADDR: begin
                                if (op_reg == OP_WRITE) begin
                                    shift_next = buf_mem[4'h0];
                                    kind_next  = K_DATA;
                                    state_next = S_TX;
                                end else begin
                                    rphase_next = 1'b1;
                                    state_next  = S_START;
                                end
                            end
                            K_DATA: begin
                                idx_next = idx_inc;
                                if (last_rx) begin
                                    state_next = S_STOP;
                                end else begin
                                    shift_next = buf_mem[idx_inc[3:0]];
                                    state_next = S_TX;
                                end
                            end
                            default: begin
                                bcnt_next  = 3'd0;
                                state_next = S_RX;
                            end
                        endcase
                    end
                end
            end
            S_RX: begin
                if (pend_reg && bdone) begin
                    pend_next  = 1'b0;
                    shift_next = {shift_reg[6:0], brx};
                    bcnt_next  = bcnt_reg + 3'd1;
                    if (bcnt_reg == 3'd7) begin
                        buf_we     = 1'b1;
                        state_next = S_RXACK;
                    end
                end
            end
            S_RXACK: begin
                if (pend_reg && bdone) begin
                    pend_next  = 1'b0;
                    idx_next   = idx_inc;
                    state_next = last_rx ? S_STOP : S_RX;
                end
            end
            S_STOP: begin
                if (pend_reg && bdone) begin
                    pend_next  = 1'b0;
                    done_set   = 1'b1;
                    state_next = S_IDLE;
                end
            end
            default: state_next = S_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg  <= S_IDLE;
            kind_reg   <= K_CTRLW;
            gcmd_reg   <= BIT_STOP;
            pend_reg   <= 1'b0;
            go_reg     <= 1'b0;
            gbit_reg   <= 1'b1;
            shift_reg  <= 8'h00;
            bcnt_reg   <= 3'd0;
            idx_reg    <= 5'h00;
            rphase_reg <= 1'b0;
        end else begin
            state_reg  <= state_next;
            kind_reg   <= kind_next;
            gcmd_reg   <= gcmd_next;
            pend_reg   <= pend_next;
            go_reg     <= go_next;
            gbit_reg   <= gbit_next;
            shift_reg  <= shift_next;
            bcnt_reg   <= bcnt_next;
            idx_reg    <= idx_next;
            rphase_reg <= rphase_next;
        end
    end

    assign avs_readdata    = rdata_reg;
    assign avs_waitrequest = wait_reg;
    assign sda_o           = sda_o_reg;
    assign wp_o            = wp_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    AST_IDLE_BEFORE_START: assert property (
        $rose(busy_reg) |-> $past(bus_idle))
        else $error("Transfer launched on a busy bus.");
    AST_CTRL_BYTE: assert property (
        (state_reg == S_START && pend_reg && bdone) |=>
            (shift_reg[7:4] == TYPE_CODE && shift_reg[0] == rphase_reg &&
             shift_reg[2:1] == addr_reg[9:8]))
        else $error("Control byte malformed.");
    AST_MSB_FIRST: assert property (
        (state_reg == S_TX && go_reg) |-> gbit_reg == shift_reg[7])
        else $error("Bit sent is not the top of the shift register.");
    AST_NINTH_CLOCK: assert property (
        (state_reg == S_TX && pend_reg && bdone && bcnt_reg == 3'd7)
            |=> state_reg == S_TXACK ##1 (go_reg && gcmd_reg == BIT_READ))
        else $error("No acknowledge slot after eight bits.");
    AST_NACK_LAST: assert property (
        (state_reg == S_RXACK && go_reg) |-> gbit_reg == last_rx)
        else $error("Read acknowledge does not match the last byte.");
    AST_NACK_STOPS: assert property (
        (state_reg == S_TXACK && pend_reg && bdone && brx) |=>
            (state_reg == S_STOP && nack_reg))
        else $error("Missing acknowledge did not lead to Stop.");
    AST_STOP_CLOSES: assert property (
        $fell(busy_reg) |-> $past(in_stop))
        else $error("Operation ended without a Stop.");
    AST_PAGE_REFUSE: assert property (
        (cmd_wr && page_bad) |=> (!busy_reg && refused_reg))
        else $error("Page-crossing write was not refused.");
    AST_BUS_ANSWER: assert property (
        (req && wait_reg) |=> !wait_reg)
        else $error("Bus answer later than one cycle.");

    COV_WRITE_DONE: cover property (
        in_stop && bdone && op_reg == OP_WRITE && !nack_reg);
    COV_SEQ_READ: cover property (
        in_stop && bdone && op_reg == OP_RAND_READ && len_reg > 5'h01);
    COV_POLL_NACK: cover property (
        in_stop && bdone && op_reg == OP_POLL && nack_reg);
endmodule

// File: eehc_eeprom_model.sv
// Behavioural two-wire serial EEPROM for the host controller bench.
// Assumes the bench resolves the data wire with a pull-up.
`timescale 1ns/100ps
module eehc_eeprom_model #(
    parameter int TWC_NS = 20000
) (
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic wp,
    output logic      pull
);
    logic [7:0]  mem [1024];
    logic [7:0]  pg [16];
    logic [7:0]  sr;
    logic [9:0]  ptr;
    logic [15:0] pm;
    logic        busy;
    int          n, st;
    initial begin
        for (int k = 0; k < 1024; k++) mem[k] = 8'(k) ^ 8'h5a;
        pull = 0;
        busy = 0;
        pm = 0;
        st = 0;
    end
    always @(negedge sda) if (scl === 1'b1) begin
        n = -1;
        st = 1;
    end
    always @(posedge sda) if (scl === 1'b1) begin
        if (pm != 0 && !wp) busy = 1;
        for (int k = 0; k < 16; k++)
            if (pm[k] && !wp) mem[{ptr[9:4], 4'(k)}] = pg[k];
        pm = 0;
        st = 0;
    end
    always @(posedge busy) #(TWC_NS) busy = 0;
    always @(posedge scl) begin
        if (n < 8) sr = {sr[6:0], sda};
        else if (st == 4 && sda) st = 0;
    end
    always @(negedge scl) begin
        n = n + 1;
        if (n == 9) n = 0;
        pull = 0;
        if (st == 4) begin
            if (n < 8) pull = !mem[ptr][7 - n];
            else ptr = ptr + 1;
        end else if (n == 8 && st == 1) begin
            pull = sr[7:4] == 4'ha && !busy;
            if (pull && !sr[0]) ptr[9:8] = sr[2:1];
            st = !pull ? 0 : sr[0] ? 4 : 2;
        end else if (n == 8 && st == 2) begin
            ptr[7:0] = sr;
            pull = 1;
            st = 3;
        end else if (n == 8 && st == 3) begin
            pg[ptr[3:0]] = sr;
            pm[ptr[3:0]] = 1;
            ptr[3:0] = ptr[3:0] + 1;
            pull = 1;
        end
    end
endmodule

// File: eehc_pkg.sv
// Shared constants and types for the two-wire EEPROM host controller.
// Assumes a 50 MHz system clock and a push-pull serial clock output.
package eehc_pkg;

    localparam int CLK_PERIOD_NS  = 20;
    localparam int SCL_PERIOD_NS  = 10000;
    localparam int QUARTER_CYCLES = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_ADDR = 8'h04;
    localparam logic [7:0] OFS_LEN  = 8'h08;
    localparam logic [7:0] OFS_STAT = 8'h0c;
    localparam logic [7:0] OFS_CFG  = 8'h10;
    localparam logic [1:0] BUF_SEL  = 2'h1;

    localparam int STAT_BUSY    = 0;
    localparam int STAT_NACK    = 1;
    localparam int STAT_DONE    = 2;
    localparam int STAT_REFUSED = 3;
    localparam int STAT_IDLE    = 4;

    localparam logic [9:0] ADDR_RST = 10'h000;
    localparam logic [4:0] LEN_RST  = 5'h01;
    localparam logic       WP_RST   = 1'h0;

    localparam logic [3:0] TYPE_CODE  = 4'ha;
    localparam logic [4:0] PAGE_BYTES = 5'h10;

    typedef enum logic [2:0] {
        OP_NONE      = 3'b000,
        OP_WRITE     = 3'b001,
        OP_POLL      = 3'b010,
        OP_CUR_READ  = 3'b011,
        OP_RAND_READ = 3'b100
    } eehc_op_t;

    typedef enum logic [1:0] {
        BIT_START = 2'b00,
        BIT_STOP  = 2'b01,
        BIT_WRITE = 2'b10,
        BIT_READ  = 2'b11
    } eehc_bit_t;

    typedef enum logic [1:0] {
        K_CTRLW = 2'b00,
        K_ADDR  = 2'b01,
        K_DATA  = 2'b10,
        K_CTRLR = 2'b11
    } eehc_kind_t;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_START = 3'b001,
        S_TX    = 3'b010,
        S_TXACK = 3'b011,
        S_RX    = 3'b100,
        S_RXACK = 3'b101,
        S_STOP  = 3'b110
    } eehc_state_t;

endpackage

// File: test_eehc_ctrl.sv
// Bench for the EEPROM host controller against a behavioural memory.
// Assumes the data wire is open drain with a pull-up resolved here.
`timescale 1ns/100ps
module test_eehc_ctrl;
    import eehc_pkg::*;
    logic        clk, rst_b, rd, wr, scl, oe, wp, wt, pull, so;
    logic [7:0]  adr, dat;
    logic [31:0] wd, rdat, q;
    logic [7:0]  ex [1024];
    int          errors, n_tests, i, a, l;
    wire         sda = !((oe && !so) || pull);
    eehc_ctrl #(.QUARTER(2)) uut (.clk(clk), .rst_b(rst_b),
        .avs_address(adr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wt),
        .scl_o(scl), .sda_i(sda), .sda_o(so), .sda_oe(oe), .wp_o(wp));
    eehc_eeprom_model mem (.scl(scl), .sda(sda), .wp(wp), .pull(pull));
    initial begin
        clk = 0;
        forever #10 clk = !clk;
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            errors++;
            $display("mismatch %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        adr <= a;
        wd <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (wt !== 1'b0);
        q = rdat;
        wr <= 0;
        rd <= 0;
        @(posedge clk);
    endtask
    task automatic run(input eehc_op_t op);
        bus(1, OFS_CTRL, {29'h0, op});
        for (int k = 0; k < 999; k++) begin
            bus(0, OFS_STAT, 0);
            if (q[STAT_BUSY] === 1'b0) break;
        end
    endtask
    task automatic rd_chk(input int a, input int l, input eehc_op_t op);
        bus(1, OFS_ADDR, 32'(a));
        bus(1, OFS_LEN, 32'(l));
        run(op);
        for (int j = 0; j < l; j++) begin
            bus(0, 8'(64 + 4 * j), 0);
            chk(q, {24'h0, ex[10'(a + j)]});
        end
    endtask
    task automatic final_report;
        $display("errors %0d comparisons %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #1000000;
        errors++;
        final_report;
    end
    initial begin
        {errors, n_tests, rd, wr, adr, wd, rst_b} = 0;
        i = $urandom(32'h717a902e);
        for (i = 0; i < 1024; i++) ex[i] = 8'(i) ^ 8'h5a;
        repeat (5) @(posedge clk);
        rst_b <= 1;
        @(posedge clk);
        bus(0, OFS_LEN, 0);
        chk(q, 32'h1);
        bus(0, 8'h20, 0);
        chk(q, 0);
        // The last pass runs with writes protected.
        for (int t = 0; t < 4; t++) begin
            a = $urandom % 1024;
            l = 1 + $urandom % (16 - a % 16);
            bus(1, OFS_CFG, t == 3);
            bus(1, OFS_ADDR, 32'(a));
            bus(1, OFS_LEN, 32'(l));
            for (i = 0; i < l; i++) begin
                dat = 8'($urandom % 256);
                if (t < 3) ex[a + i] = dat;
                bus(1, 8'(64 + 4 * i), {24'h0, dat});
            end
            run(OP_WRITE);
            chk(q, 32'h14);
            run(OP_POLL);
            chk(q, t < 3 ? 32'h16 : 32'h14);
            for (i = 0; i < 99 && q[STAT_NACK] !== 1'b0; i++) run(OP_POLL);
            chk(q, 32'h14);
            bus(1, OFS_CFG, 0);
            rd_chk(a, l, OP_RAND_READ);
            rd_chk(a + l, 1, OP_CUR_READ);
        end
        rd_chk(1022, 4, OP_RAND_READ);
        bus(1, OFS_ADDR, 32'h8);
        bus(1, OFS_LEN, 32'h9);
        run(OP_WRITE);
        chk(q, 32'h18);
        bus(0, OFS_ADDR, 0);
        chk(q, 32'h8);
        bus(0, OFS_CTRL, 0);
        chk(q, {29'h0, OP_RAND_READ});
        final_report;
    end
endmodule
